/* File: rtl/sep_consts.svh */
/*
 * Constants of the SRAM check-code protection unit: check-code masks,
 * register offsets, field positions and write-strobe patterns.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

// ***********************************************
// check-code masks, one per check bit
// ***********************************************
`define SEP_MASK0 16'h443F
`define SEP_MASK1 16'h13C7
`define SEP_MASK2 16'hE1D1
`define SEP_MASK3 16'hEE60
`define SEP_MASK4 16'h3E8A
`define SEP_MASK5 16'h993C

// ***********************************************
// sizes
// ***********************************************
`define SEP_ADDR_W 10
`define SEP_BUS_AW 16
`define SEP_APB_AW 12

// ***********************************************
// register byte offsets
// ***********************************************
`define SEP_OFS_STATUS 8'h00
`define SEP_OFS_IRQ_EN 8'h04
`define SEP_OFS_FLAG 8'h08
`define SEP_OFS_DEBUG_POINTER 8'h0C
`define SEP_OFS_DEBUG_RAW_DATA 8'h10
`define SEP_OFS_DCHK 8'h14
`define SEP_OFS_DCMD 8'h18

// ***********************************************
// field positions
// ***********************************************
`define SEP_BIT_READY 0
`define SEP_BIT_SBE_EN 0
`define SEP_BIT_SBE_FLAG 0
`define SEP_BIT_RRD 7
`define SEP_BIT_DW 1
`define SEP_BIT_DR 0

// ***********************************************
// aligned write strobe patterns
// ***********************************************
`define SEP_STRB_WORD 4'hF
`define SEP_STRB_LO 4'h3
`define SEP_STRB_HI 4'hC

`endif

/* File: rtl/sep_pkg.sv */
/*
 * Types and the check-code generator shared by the protection unit.
 * Assumes sep_consts.svh is on the include path.
 */
`include "sep_consts.svh"

package sep_pkg;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic [`SEP_BUS_AW-1:0] addr;
		logic [3:0] strb;
		logic [31:0] wdata;
	} sep_req_type;

	typedef struct packed
	{
		logic ack;
		logic dbl_err;
		logic [31:0] rdata;
	} sep_rsp_type;

	typedef enum logic [1:0] {st_init, st_idle, st_rmw, st_gap} sep_state_type;

	// each check bit is the inverted parity of the masked data
	function automatic logic [5:0] sep_ecc_gen(input logic [15:0] d);
		logic [5:0] g;
		g[0] = ~^(d & `SEP_MASK0);
		g[1] = ~^(d & `SEP_MASK1);
		g[2] = ~^(d & `SEP_MASK2);
		g[3] = ~^(d & `SEP_MASK3);
		g[4] = ~^(d & `SEP_MASK4);
		g[5] = ~^(d & `SEP_MASK5);
		return g;
	endfunction

endpackage

/* File: rtl/sep_ecc_check.sv */
/*
 * Checker for one 16-bit word and its 6-bit check code: flags single and
 * double errors and returns the corrected word.
 * Assumes purely combinational use; no clock.
 */
`timescale 1ns/1ps

module sep_ecc_check
	import sep_pkg::*;
(
	input wire logic [15:0] data,
	input wire logic [5:0] check,
	output logic [15:0] fixed,
	output logic single,
	output logic double
);

	logic [5:0] syn;
	logic hit;

	always_comb
	begin
		syn = check ^ sep_ecc_gen(data);
		hit = 1'b0;
		fixed = data;
		// column of bit i is the code change a lone flip of bit i causes
		for (int i = 0; i < 16; i++)
		begin
			if (syn == (sep_ecc_gen(16'h0001 << i) ^ sep_ecc_gen(16'h0000)))
			begin
				fixed[i] = ~data[i];
				hit = 1'b1;
			end
		end
		// a lone syndrome bit is a flipped check bit, data is already good
		single = (syn != 6'h00) && (hit || $onehot(syn));
		double = (syn != 6'h00) && !single;
	end

endmodule

/* File: rtl/sep_ecc_unit.sv */
/*
 * SRAM check-code protection unit: memory array with 6 check bits per
 * 16-bit half, aligned and merged writes, checked reads with repair,
 * power-up clearing, debug raw access and an APB register file.
 * Assumes one clock, a bus initiator that holds its request until ack,
 * and the chip mode level special_mode synchronous to pclk.
 */
// Contract
// RQ1 - command reads always, writes only special mode
// RQ2 - bit 7 set disables read repair
// RQ3 - bit 1 stores raw word, then clears
// RQ4 - bit 0 reads raw word, then clears
// RQ5 - both bits set: only write runs
// RQ6 - no new command while one pending
// RQ7 - 1..4 byte writes, code per half
// RQ8 - aligned half/word writes take one cycle
// RQ9 - other writes read, merge, write back
// RQ10 - merge onto corrected data, flag single error
// RQ11 - double error blocks write, informs initiator
// RQ12 - reads corrected, flagged, repaired unless disabled
// RQ13 - read after repair waits one cycle; no wait if the other half has a double error
// RQ14 - double error on read marks data invalid
// RQ15 - power-up clears memory, holds ready low
// RQ16 - interrupt on enabled single-error flag only
// RQ17 - check bits are inverted masked parities
// RQ18 - flag cleared only by writing one
// RQ19 - debug lowest priority, waits for init
// RQ20 - debug skips checking and error flags
// RQ21 - separate double-error output with answers
`timescale 1ns/1ps

module sep_ecc_unit
	import sep_pkg::*;
#(
	parameter int ADDR_W = `SEP_ADDR_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SEP_APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic special_mode,
	input wire sep_req_type bus_req,
	output sep_rsp_type bus_rsp,
	output logic init_done,
	output logic irq
);

	// ***********************************************
	// storage
	// ***********************************************
	localparam int HALVES = 2 ** (ADDR_W + 1);

	logic [15:0] data_mem [HALVES];
	logic [5:0] chk_mem [HALVES];

	sep_state_type state;
	logic [ADDR_W-1:0] init_cnt;
	logic [ADDR_W-1:0] rmw_word;
	logic [31:0] rmw_data;
	logic [1:0] rmw_halves;

	logic irq_en;
	logic sbe_flag;
	logic [ADDR_W:0] debug_pointer;
	logic [15:0] debug_raw_data;
	logic [5:0] debug_raw_check;
	logic read_repair_disable;
	logic debug_write_cmd;
	logic debug_read_cmd;

	// ***********************************************
	// read and check
	// ***********************************************
	logic [ADDR_W-1:0] word_idx;
	logic [15:0] fix_lo;
	logic [15:0] fix_hi;
	logic sgl_lo;
	logic sgl_hi;
	logic dbl_lo;
	logic dbl_hi;

	assign word_idx = bus_req.addr[ADDR_W-1:0];

	sep_ecc_check u_chk_lo
	(
		.data(data_mem[{word_idx, 1'b0}]),
		.check(chk_mem[{word_idx, 1'b0}]),
		.fixed(fix_lo),
		.single(sgl_lo),
		.double(dbl_lo)
	);

	sep_ecc_check u_chk_hi
	(
		.data(data_mem[{word_idx, 1'b1}]),
		.check(chk_mem[{word_idx, 1'b1}]),
		.fixed(fix_hi),
		.single(sgl_hi),
		.double(dbl_hi)
	);

	function automatic logic [31:0] sep_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				m[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// ***********************************************
	// request decode
	// ***********************************************
	logic take;
	logic full_wr;
	logic [1:0] touched;
	logic rmw_dbl;
	logic rmw_sgl;
	logic rd_dbl;
	logic [1:0] repair;
	logic dbg_go;
	logic sbe_evt;

	always_comb
	begin
		// an acked request is still on the bus for one cycle; never retake it
		take = (state == st_idle) && bus_req.valid && !bus_rsp.ack;
		full_wr = (bus_req.strb == `SEP_STRB_WORD) || (bus_req.strb == `SEP_STRB_LO) ||
			(bus_req.strb == `SEP_STRB_HI); // RQ8
		touched = {|bus_req.strb[3:2], |bus_req.strb[1:0]}; // RQ7
		rmw_dbl = (touched[0] && dbl_lo) || (touched[1] && dbl_hi);
		rmw_sgl = (touched[0] && sgl_lo) || (touched[1] && sgl_hi);
		rd_dbl = dbl_lo || dbl_hi;
		repair = {sgl_hi, sgl_lo} & {2{!read_repair_disable}}; // RQ2 RQ12
		// debug waits for idle, init done and no bus work
		dbg_go = (state == st_idle) && !take && (debug_write_cmd || debug_read_cmd); // RQ19
		sbe_evt = take && (bus_req.write ? (!full_wr && !rmw_dbl && rmw_sgl) : (sgl_lo || sgl_hi)); // RQ10 RQ12
	end

	// ***********************************************
	// write port select
	// ***********************************************
	logic we_lo;
	logic we_hi;
	logic [ADDR_W:0] wa_lo;
	logic [ADDR_W:0] wa_hi;
	logic [15:0] wd_lo;
	logic [15:0] wd_hi;
	logic [5:0] wc_lo;
	logic [5:0] wc_hi;

	always_comb
	begin
		we_lo = 1'b0;
		we_hi = 1'b0;
		wa_lo = {word_idx, 1'b0};
		wa_hi = {word_idx, 1'b1};
		wd_lo = bus_req.wdata[15:0];
		wd_hi = bus_req.wdata[31:16];
		unique case (state)
			st_init:
			begin
				we_lo = 1'b1; // RQ15
				we_hi = 1'b1;
				wa_lo = {init_cnt, 1'b0};
				wa_hi = {init_cnt, 1'b1};
				wd_lo = 16'h0000;
				wd_hi = 16'h0000;
			end
			st_idle:
			begin
				if (take && bus_req.write && full_wr)
				begin
					we_lo = touched[0]; // RQ8
					we_hi = touched[1];
				end
				else if (take && !bus_req.write)
				begin
					// repair runs beside the answer, same cycle
					we_lo = repair[0]; // RQ12
					we_hi = repair[1];
					wd_lo = fix_lo;
					wd_hi = fix_hi;
				end
				else if (dbg_go && debug_write_cmd)
				begin
					we_lo = 1'b1; // RQ3 RQ5
					wa_lo = debug_pointer;
					wd_lo = debug_raw_data;
				end
			end
			st_rmw:
			begin
				we_lo = rmw_halves[0]; // RQ9
				we_hi = rmw_halves[1];
				wa_lo = {rmw_word, 1'b0};
				wa_hi = {rmw_word, 1'b1};
				wd_lo = rmw_data[15:0];
				wd_hi = rmw_data[31:16];
			end
			st_gap:
			begin
				we_lo = 1'b0;
			end
		endcase
		wc_lo = sep_ecc_gen(wd_lo); // RQ17
		wc_hi = sep_ecc_gen(wd_hi);
		// debug writes the raw check value unchanged
		if (state == st_idle && !take && dbg_go && debug_write_cmd)
		begin
			wc_lo = debug_raw_check; // RQ20
		end
	end

	// no reset on the array; power-up clearing fills it instead
	always_ff @(posedge pclk)
	begin
		if (we_lo)
		begin
			data_mem[wa_lo] <= wd_lo;
			chk_mem[wa_lo] <= wc_lo;
		end
		if (we_hi)
		begin
			data_mem[wa_hi] <= wd_hi;
			chk_mem[wa_hi] <= wc_hi;
		end
	end

	// ***********************************************
	// sequencer
	// ***********************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= st_init;
			init_cnt <= '0;
			init_done <= 1'b0;
		end
		else
		begin
			unique case (state)
				st_init:
				begin
					init_cnt <= init_cnt + 1'b1;
					if (&init_cnt)
					begin
						state <= st_idle;
						init_done <= 1'b1; // RQ15
					end
				end
				st_idle:
				begin
					if (take && bus_req.write && !full_wr && !rmw_dbl)
					begin
						state <= st_rmw; // RQ9
					end
					else if (take && !bus_req.write && !rd_dbl && (|repair))
					begin
						state <= st_gap; // RQ13
					end
				end
				st_rmw:
				begin
					state <= st_idle;
				end
				st_gap:
				begin
					// the answer cycle already blocks a take, so hold one more
					if (!bus_rsp.ack)
					begin
						state <= st_idle; // RQ13
					end
				end
			endcase
		end
	end

	// merge onto corrected data so the write also heals a single error in each half it writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rmw_word <= '0;
			rmw_data <= 32'h0000_0000;
			rmw_halves <= 2'b00;
		end
		else if (take && bus_req.write && !full_wr)
		begin
			rmw_word <= word_idx;
			rmw_data <= sep_merge({fix_hi, fix_lo}, bus_req.wdata, bus_req.strb); // RQ10
			rmw_halves <= touched;
		end
	end

	// ***********************************************
	// bus answer
	// ***********************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_rsp <= '0;
		end
		else
		begin
			bus_rsp.ack <= 1'b0;
			bus_rsp.dbl_err <= 1'b0;
			if (take && !bus_req.write)
			begin
				bus_rsp.ack <= 1'b1;
				bus_rsp.rdata <= {fix_hi, fix_lo};
				bus_rsp.dbl_err <= rd_dbl; // RQ14 RQ21
			end
			else if (take && (full_wr || rmw_dbl))
			begin
				bus_rsp.ack <= 1'b1;
				bus_rsp.dbl_err <= !full_wr; // RQ11 RQ21
			end
			else if (state == st_rmw)
			begin
				bus_rsp.ack <= 1'b1;
			end
		end
	end

	// ***********************************************
	// apb registers
	// ***********************************************
	logic setup;
	logic wr_acc;
	logic mapped;
	logic dbg_busy;
	logic [31:0] rd_val;
	logic [7:0] ofs;

	always_comb
	begin
		setup = psel && !penable;
		wr_acc = psel && penable && pready && pwrite && !pslverr;
		ofs = paddr[7:0];
		mapped = (paddr[`SEP_APB_AW-1:8] == '0) && (ofs <= `SEP_OFS_DCMD) && (ofs[1:0] == 2'b00);
		dbg_busy = debug_write_cmd || debug_read_cmd;
		rd_val = 32'h0000_0000;
		unique case (ofs)
			`SEP_OFS_STATUS: rd_val[`SEP_BIT_READY] = init_done;
			`SEP_OFS_IRQ_EN: rd_val[`SEP_BIT_SBE_EN] = irq_en;
			`SEP_OFS_FLAG: rd_val[`SEP_BIT_SBE_FLAG] = sbe_flag; // RQ18
			`SEP_OFS_DEBUG_POINTER: rd_val[ADDR_W+1:1] = debug_pointer;
			`SEP_OFS_DEBUG_RAW_DATA: rd_val[15:0] = debug_raw_data;
			`SEP_OFS_DCHK: rd_val[5:0] = debug_raw_check;
			`SEP_OFS_DCMD:
			begin
				rd_val[`SEP_BIT_RRD] = read_repair_disable; // RQ1
				rd_val[`SEP_BIT_DW] = debug_write_cmd;
				rd_val[`SEP_BIT_DR] = debug_read_cmd;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// answer is prepared in setup, so pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup)
			begin
				prdata <= rd_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_en <= 1'b0;
			sbe_flag <= 1'b0;
			debug_pointer <= '0;
			debug_raw_data <= 16'h0000;
			debug_raw_check <= 6'h00;
			read_repair_disable <= 1'b0;
			debug_write_cmd <= 1'b0;
			debug_read_cmd <= 1'b0;
		end
		else
		begin
			if (wr_acc && ofs == `SEP_OFS_IRQ_EN)
			begin
				irq_en <= pwdata[`SEP_BIT_SBE_EN];
			end
			// a new error in the clearing cycle keeps the flag set
			if (sbe_evt)
			begin
				sbe_flag <= 1'b1; // RQ10 RQ12
			end
			else if (wr_acc && ofs == `SEP_OFS_FLAG && pwdata[`SEP_BIT_SBE_FLAG])
			begin
				sbe_flag <= 1'b0; // RQ18
			end
			if (wr_acc && ofs == `SEP_OFS_DEBUG_POINTER)
			begin
				debug_pointer <= pwdata[ADDR_W+1:1];
			end
			if (wr_acc && ofs == `SEP_OFS_DEBUG_RAW_DATA)
			begin
				debug_raw_data <= pwdata[15:0];
			end
			if (wr_acc && ofs == `SEP_OFS_DCHK)
			begin
				debug_raw_check <= pwdata[5:0];
			end
			if (wr_acc && ofs == `SEP_OFS_DCMD && special_mode) // RQ1
			begin
				read_repair_disable <= pwdata[`SEP_BIT_RRD]; // RQ2
				if (!dbg_busy) // RQ6
				begin
					if (pwdata[`SEP_BIT_DW])
					begin
						debug_write_cmd <= 1'b1; // RQ5
					end
					else if (pwdata[`SEP_BIT_DR])
					begin
						debug_read_cmd <= 1'b1;
					end
				end
			end
			if (dbg_go && debug_write_cmd)
			begin
				debug_write_cmd <= 1'b0; // RQ3
			end
			else if (dbg_go)
			begin
				// raw contents, no check and no repair
				debug_raw_data <= data_mem[debug_pointer]; // RQ4 RQ20
				debug_raw_check <= chk_mem[debug_pointer];
				debug_read_cmd <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= sbe_flag && irq_en; // RQ16
		end
	end

endmodule

/* File: verification/sep_bus_initiator.sv */
/* system bus initiator model for the protection unit
   assumes pclk is the unit's clock and calls come just after a rising edge */
`timescale 1ns/1ps

module sep_bus_initiator
	import sep_pkg::*;
(
	input wire logic pclk,
	output sep_req_type bus_req,
	input wire sep_rsp_type bus_rsp
);
	initial bus_req = '0;

	// released fields are inverted so a stale request never looks valid by luck
	task automatic xfer(input int gap, input logic w, input logic [15:0] a, input logic [3:0] s,
		input logic [31:0] d, output sep_rsp_type r);
		repeat (gap) @(posedge pclk);
		bus_req <= '{valid: 1'h1, write: w, addr: a, strb: s, wdata: d};
		do @(posedge pclk); while (bus_rsp.ack !== 1'h1);
		r = bus_rsp;
		bus_req <= {1'h0, ~bus_req[$bits(sep_req_type)-2:0]};
		@(posedge pclk);
	endtask

	// two reads of one word, valid kept up; n counts edges from first answer to second
	task automatic read_pair(input logic [15:0] a, output sep_rsp_type r, output int n);
		bus_req <= '{valid: 1'h1, write: 1'h0, addr: a, strb: 4'h0, wdata: 32'h0};
		do @(posedge pclk); while (bus_rsp.ack !== 1'h1);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (bus_rsp.ack !== 1'h1);
		r = bus_rsp;
		bus_req <= {1'h0, ~bus_req[$bits(sep_req_type)-2:0]};
		@(posedge pclk);
	endtask
endmodule

/* File: verification/sep_ecc_unit_checker.sv */
/* port checker of the protection unit, bound to sep_ecc_unit
   assumes one clock pclk and reset presetn active low */
`timescale 1ns/1ps
`include "sep_consts.svh"

module sep_ecc_unit_checker
	import sep_pkg::*;
#(
	parameter int ADDR_W = 10
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SEP_APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic special_mode,
	input wire sep_req_type bus_req,
	input wire sep_rsp_type bus_rsp,
	input wire logic init_done,
	input wire logic irq
);
	localparam int DEPTH = 2 ** ADDR_W;
	int unsigned init_cnt;
	logic wr_odd;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	assign wr_odd = bus_req.write && !(bus_req.strb inside {`SEP_STRB_WORD, `SEP_STRB_LO, `SEP_STRB_HI});

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			init_cnt <= 0;
		else if (!init_done)
			init_cnt <= init_cnt + 1;
	end

	// ********************
	// properties
	// ********************
	init_block_a: assert property (!init_done |-> !bus_rsp.ack)
		else $error("bus answered while clearing");
	init_length_a: assert property ($rose(init_done) |-> init_cnt == DEPTH)
		else $error("clearing took the wrong number of cycles");
	merge_two_a: assert property (bus_rsp.ack && wr_odd && !bus_rsp.dbl_err
		|-> !$past(bus_rsp.ack) && $past(bus_req.valid, 2))
		else $error("merged write answered too early");
	bus_bound_a: assert property (bus_req.valid && !bus_rsp.ack && init_done |-> ##[1:6] bus_rsp.ack)
		else $error("bus request starved");
	dbl_with_ack_a: assert property (bus_rsp.dbl_err |-> bus_rsp.ack)
		else $error("double error outside an answer");
	debug_silent_a: assert property (bus_rsp.ack |-> bus_req.valid)
		else $error("answer without a bus request");
	irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite
		&& (paddr == `SEP_OFS_FLAG || paddr == `SEP_OFS_IRQ_EN), 2))
		else $error("interrupt dropped without a clear");
	rdata_hold_a: assert property ($changed(bus_rsp.rdata) |-> bus_rsp.ack)
		else $error("read data changed without an answer");

	cover property (bus_rsp.ack && bus_rsp.dbl_err);
	cover property ($rose(irq));
	cover property (bus_rsp.ack && wr_odd);
endmodule

bind sep_ecc_unit sep_ecc_unit_checker #(.ADDR_W(ADDR_W)) u_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .special_mode(special_mode), .bus_req(bus_req),
	.bus_rsp(bus_rsp), .init_done(init_done), .irq(irq));

/* File: verification/tb_sep_ecc_unit.sv */
/* self-checking bench of the protection unit
   assumes sep_pkg, the initiator model and the bound checker are compiled first */
`timescale 1ns/1ps
`include "sep_consts.svh"

module tb_sep_ecc_unit
	import sep_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, special_mode, pready, pslverr, init_done, irq, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, lfsr, rd, d;
	sep_req_type bus_req;
	sep_rsp_type bus_rsp, r;
	int errors, checked, n;
	logic [3:0] strbs [8] = '{4'hF, 4'h3, 4'hC, 4'h1, 4'h6, 4'h7, 4'h8, 4'hE};

	// small memory keeps clearing short
	sep_ecc_unit #(.ADDR_W(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.special_mode(special_mode), .bus_req(bus_req), .bus_rsp(bus_rsp), .init_done(init_done), .irq(irq));
	sep_bus_initiator u_init (.pclk(pclk), .bus_req(bus_req), .bus_rsp(bus_rsp));

	// ********************
	// helpers
	// ********************
	function automatic logic [5:0] ecc16(input logic [15:0] v);
		logic [95:0] m;
		m = {`SEP_MASK5, `SEP_MASK4, `SEP_MASK3, `SEP_MASK2, `SEP_MASK1, `SEP_MASK0};
		for (int i = 0; i < 6; i++)
			ecc16[i] = ~^(v & m[16*i +: 16]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
	endfunction

	function automatic logic [31:0] step(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	// ptr is the byte address of one half; waits until both command bits are clear
	task automatic dbg(input logic [11:0] ptr, input logic [15:0] dd, input logic [5:0] dc, input logic [7:0] cmd);
		apb(1'h1, `SEP_OFS_DEBUG_POINTER, {20'h0, ptr});
		apb(1'h1, `SEP_OFS_DEBUG_RAW_DATA, {16'h0, dd});
		apb(1'h1, `SEP_OFS_DCHK, {26'h0, dc});
		apb(1'h1, `SEP_OFS_DCMD, {24'h0, cmd});
		do apb(1'h0, `SEP_OFS_DCMD, 32'h0); while (rd[1:0] !== 2'h0);
	endtask

	task automatic tally_and_finish();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end

	// about forty times the expected run
	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		tally_and_finish();
	end

	// ********************
	// tests
	// ********************
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		special_mode = 1'h0;
		lfsr = 32'h80;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		do @(posedge pclk); while (init_done !== 1'h1);
		apb(1'h0, `SEP_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		u_init.xfer(0, 1'h0, 16'h9, 4'h0, 32'h0, r);
		chk(r.rdata, 32'h0);
		apb(1'h0, 12'h01C, 32'h0);
		chk({31'h0, perr}, 32'h1);
		$display("test init done");
		for (int i = 0; i < 16; i++)
		begin
			lfsr = step(lfsr);
			d = lfsr;
			lfsr = step(lfsr);
			u_init.xfer(lfsr[1:0], 1'h1, {12'h0, lfsr[7:4]}, 4'hF, d, r);
			u_init.xfer(0, 1'h1, {12'h0, lfsr[7:4]}, strbs[i % 8], lfsr, r);
			u_init.xfer(lfsr[3:2], 1'h0, {12'h0, lfsr[7:4]}, 4'h0, 32'h0, r);
			chk(r.rdata, merge(d, lfsr, strbs[i % 8]));
			chk({31'h0, r.dbl_err}, 32'h0);
		end
		$display("test writes done");
		u_init.xfer(0, 1'h1, 16'h2, 4'hF, 32'h1234ABCD, r);
		dbg(12'h008, 16'hABCC, ecc16(16'hABCD), 8'h02);
		u_init.xfer(0, 1'h0, 16'h2, 4'h0, 32'h0, r);
		chk({31'h0, r.dbl_err}, 32'h0);
		apb(1'h0, `SEP_OFS_FLAG, 32'h0);
		chk(rd, 32'h0);
		special_mode <= 1'h1;
		apb(1'h1, `SEP_OFS_IRQ_EN, 32'h1);
		dbg(12'h008, 16'hABCC, ecc16(16'hABCD), 8'h03);
		u_init.read_pair(16'h2, r, n);
		chk(r.rdata, 32'h1234ABCD);
		chk(n, 3);
		u_init.read_pair(16'h2, r, n);
		chk(n, 2);
		apb(1'h0, `SEP_OFS_FLAG, 32'h0);
		chk(rd, 32'h1);
		chk({31'h0, irq}, 32'h1);
		dbg(12'h008, 16'h0, 6'h0, 8'h01);
		apb(1'h0, `SEP_OFS_DEBUG_RAW_DATA, 32'h0);
		chk(rd, 32'hABCD);
		apb(1'h0, `SEP_OFS_DCHK, 32'h0);
		chk(rd, {26'h0, ecc16(16'hABCD)});
		apb(1'h1, `SEP_OFS_FLAG, 32'h0);
		apb(1'h0, `SEP_OFS_FLAG, 32'h0);
		chk(rd, 32'h1);
		apb(1'h1, `SEP_OFS_FLAG, 32'h1);
		apb(1'h0, `SEP_OFS_FLAG, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test single error done");
		dbg(12'h00A, 16'h1235, ecc16(16'h1234), 8'h82);
		u_init.xfer(0, 1'h0, 16'h2, 4'h0, 32'h0, r);
		chk(r.rdata, 32'h1234ABCD);
		dbg(12'h00A, 16'h0, 6'h0, 8'h81);
		apb(1'h0, `SEP_OFS_DEBUG_RAW_DATA, 32'h0);
		chk(rd, 32'h1235);
		apb(1'h1, `SEP_OFS_FLAG, 32'h1);
		u_init.xfer(0, 1'h1, 16'h2, 4'h8, 32'h77000000, r);
		apb(1'h0, `SEP_OFS_FLAG, 32'h0);
		chk(rd, 32'h1);
		u_init.xfer(0, 1'h0, 16'h2, 4'h0, 32'h0, r);
		chk(r.rdata, 32'h7734ABCD);
		dbg(12'h00A, 16'h0, 6'h0, 8'h81);
		apb(1'h0, `SEP_OFS_DCHK, 32'h0);
		chk(rd, {26'h0, ecc16(16'h7734)});
		$display("test repair off done");
		dbg(12'h008, 16'hABCE, ecc16(16'hABCD), 8'h82);
		u_init.xfer(0, 1'h0, 16'h2, 4'h0, 32'h0, r);
		chk({31'h0, r.dbl_err}, 32'h1);
		u_init.xfer(0, 1'h1, 16'h2, 4'h1, 32'h55, r);
		chk({31'h0, r.dbl_err}, 32'h1);
		dbg(12'h008, 16'h0, 6'h0, 8'h81);
		apb(1'h0, `SEP_OFS_DEBUG_RAW_DATA, 32'h0);
		chk(rd, 32'hABCE);
		$display("test double error done");
		tally_and_finish();
	end
endmodule
